// file: include/mcx_params.svh
`ifndef MCX_PARAMS_SVH
`define MCX_PARAMS_SVH

// ----------------------------------------------------------------
// reset values and fixed data-space addresses
// ----------------------------------------------------------------
`define MCX_RST_PC      12'h000
`define MCX_RST_BYTE    8'h00
`define MCX_ADDR_PTR_X  8'h80
`define MCX_ADDR_PTR_Y  8'h81
`define MCX_STACK_DEPTH 6

// ----------------------------------------------------------------
// opcode classes, held in opcode bits [3:0]
// ----------------------------------------------------------------
`define MCX_CLS_CALL 4'h1
`define MCX_CLS_JUMP 4'h9
`define MCX_CLS_BTB  4'h3
`define MCX_CLS_BSR  4'hb
`define MCX_CLS_ACC  4'h5
`define MCX_CLS_DIR  4'hd
`define MCX_CLS_INDX 4'h7
`define MCX_CLS_INDY 4'hf

// ----------------------------------------------------------------
// opcode field positions
// ----------------------------------------------------------------
`define MCX_FN_LSB   4
`define MCX_BIT_LSB  5
`define MCX_POL_POS  4
`define MCX_BACK_POS 3
`define MCX_RPOL_POS 2
`define MCX_RFLG_POS 1

// ----------------------------------------------------------------
// cycle counts and instruction lengths
// ----------------------------------------------------------------
`define MCX_CYC_SHORT 3'h2
`define MCX_CYC_STD   3'h4
`define MCX_CYC_BTB   3'h5
`define MCX_NB_ONE    12'h001
`define MCX_NB_TWO    12'h002
`define MCX_NB_THREE  12'h003

`endif

// file: include/mcx_pkg.sv
package mcx_pkg;

  typedef enum logic [2:0] {
    mcx_st_run  = 3'b001,
    mcx_st_wait = 3'b010,
    mcx_st_stop = 3'b100
  } mcx_state_t;

  typedef enum logic [3:0] {
    mcx_fn_add  = 4'h0,
    mcx_fn_and  = 4'h1,
    mcx_fn_cp   = 4'h2,
    mcx_fn_sub  = 4'h3,
    mcx_fn_inc  = 4'h4,
    mcx_fn_dec  = 4'h5,
    mcx_fn_clr  = 4'h6,
    mcx_fn_com  = 4'h7,
    mcx_fn_rlc  = 4'h8,
    mcx_fn_sla  = 4'h9,
    mcx_fn_nop  = 4'ha,
    mcx_fn_ret  = 4'hb,
    mcx_fn_return_from_interrupt = 4'hc,
    mcx_fn_stop = 4'hd,
    mcx_fn_wait = 4'he,
    mcx_fn_nop2 = 4'hf
  } mcx_func_t;

endpackage

// file: include/mcx_alu_if.sv
`timescale 1ns/1ps
interface mcx_alu_if;
  mcx_pkg::mcx_func_t func;
  logic [7:0]         a;
  logic [7:0]         b;
  logic               cin;
  logic [7:0]         res;
  logic               z;
  logic               c;

  modport core (output func, output a, output b, output cin,
                input res, input z, input c);
  modport alu  (input func, input a, input b, input cin,
                output res, output z, output c);
endinterface

// file: verilog/mcx_alu.sv
`timescale 1ns/1ps
module mcx_alu (
  mcx_alu_if.alu bus
);

  // ----------------------------------------------------------------
  // combinational datapath; a is always the accumulator
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] sum;
    sum     = 9'h000;
    bus.res = bus.a;
    bus.c   = bus.cin;
    case (bus.func)
      mcx_pkg::mcx_fn_add: begin
        sum     = {1'b0, bus.a} + {1'b0, bus.b};
        bus.res = sum[7:0];
        bus.c   = sum[8];
      end
      mcx_pkg::mcx_fn_and: begin
        bus.res = bus.a & bus.b;
        bus.c   = 1'b0;
      end
      mcx_pkg::mcx_fn_cp, mcx_pkg::mcx_fn_sub: begin
        // carry is the borrow: set when a is below b
        sum     = {1'b0, bus.a} - {1'b0, bus.b};
        bus.res = sum[7:0];
        bus.c   = sum[8];
      end
      mcx_pkg::mcx_fn_inc: bus.res = bus.b + 8'h01;
      mcx_pkg::mcx_fn_dec: bus.res = bus.b - 8'h01;
      mcx_pkg::mcx_fn_clr: begin
        bus.res = 8'h00;
        bus.c   = 1'b0;
      end
      mcx_pkg::mcx_fn_com: begin
        bus.res = ~bus.a;
        bus.c   = bus.a[7];
      end
      mcx_pkg::mcx_fn_rlc: {bus.c, bus.res} = {bus.a, bus.cin};
      mcx_pkg::mcx_fn_sla: {bus.c, bus.res} = {bus.a, 1'b0};
      default:             bus.res = bus.a;
    endcase
    bus.z = (bus.res == 8'h00);
  end

endmodule

// file: verilog/mcx_core.sv
`timescale 1ns/1ps
`include "mcx_params.svh"
module mcx_core #(
  parameter int STACK_DEPTH = `MCX_STACK_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  output logic [11:0]      pm_addr,
  input  wire logic [7:0]  pm_rdata,
  output logic [7:0]       ds_addr,
  input  wire logic [7:0]  ds_rdata,
  output logic [7:0]       ds_wdata,
  output logic             ds_we,
  input  wire logic        irq_req,
  input  wire logic [11:0] irq_vec,
  input  wire logic        wdog_sel,
  output logic [7:0]       acc,
  output logic             flag_z,
  output logic             flag_c,
  output logic             wait_mode,
  output logic             stop_mode,
  output logic             instr_done
);

  if (STACK_DEPTH < 2 || STACK_DEPTH > 8) begin : g_bad_depth
    $error("mcx_core: STACK_DEPTH must lie in 2..8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mcx_pkg::mcx_state_t state_q, state_d;
  logic [2:0]  step_q, step_d;
  logic [11:0] pc_q, pc_d, pm_addr_q, pm_addr_d;
  logic [7:0]  op_q, b2_q, opnd_q, ee_q, acc_q, acc_d;
  logic [7:0]  ds_addr_q, ds_addr_d, ds_wdata_q;
  logic        bit_q, ds_we_q, done_q;
  logic        z_q, c_q, z_d, c_d, zs_q, cs_q, in_irq_q;
  logic [2:0]  sp_q, sp_d;
  logic [11:0] stk_q [STACK_DEPTH];

  mcx_alu_if alu_bus ();

  // ----------------------------------------------------------------
  // decode; the opcode is live on pm_rdata during step 0
  // ----------------------------------------------------------------
  wire       running = (state_q == mcx_pkg::mcx_st_run);
  wire       halted  = ~running;
  wire       st0     = running & (step_q == 3'h0);
  wire       st1     = running & (step_q == 3'h1);
  wire       st2     = running & (step_q == 3'h2);
  wire [7:0] op_w    = (step_q == 3'h0) ? pm_rdata : op_q;
  wire [3:0] cls_w   = op_w[3:0];
  wire [3:0] fnr_w   = op_w[`MCX_FN_LSB +: 4];
  wire [2:0] bnum_w  = op_w[`MCX_BIT_LSB +: 3];
  mcx_pkg::mcx_func_t fn_w;
  assign fn_w = mcx_pkg::mcx_func_t'(fnr_w);

  wire is_rel  = ~op_w[0];
  wire is_call = (cls_w == `MCX_CLS_CALL);
  wire is_jump = (cls_w == `MCX_CLS_JUMP);
  wire is_btb  = (cls_w == `MCX_CLS_BTB);
  wire is_bsr  = (cls_w == `MCX_CLS_BSR);
  wire is_acc  = (cls_w == `MCX_CLS_ACC);
  wire is_ptr  = (cls_w == `MCX_CLS_INDX) | (cls_w == `MCX_CLS_INDY);
  wire is_dir  = (cls_w == `MCX_CLS_DIR);
  wire is_mem  = is_dir | is_ptr;

  wire fn_two  = (fnr_w <= mcx_pkg::mcx_fn_sub);
  wire fn_cp   = (fn_w == mcx_pkg::mcx_fn_cp);
  wire fn_step = (fn_w == mcx_pkg::mcx_fn_inc) |
                 (fn_w == mcx_pkg::mcx_fn_dec);
  wire fn_clr  = (fn_w == mcx_pkg::mcx_fn_clr);
  wire fn_rot  = (fnr_w >= mcx_pkg::mcx_fn_com) &
                 (fnr_w <= mcx_pkg::mcx_fn_sla);
  wire fn_alu  = (fnr_w <= mcx_pkg::mcx_fn_sla);
  wire is_ctl  = is_acc & ~fn_alu;
  wire is_return_from_interrupt = is_ctl & (fn_w == mcx_pkg::mcx_fn_return_from_interrupt);
  wire is_ret  = is_return_from_interrupt | (is_ctl & (fn_w == mcx_pkg::mcx_fn_ret));

  // ----------------------------------------------------------------
  // length in cycles and in bytes
  // ----------------------------------------------------------------
  wire [2:0] len_w = (is_rel | is_ctl) ? `MCX_CYC_SHORT :
                     is_btb ? `MCX_CYC_BTB :
                     `MCX_CYC_STD;
  wire last_w = running & (step_q == len_w - 3'h1);
  wire [11:0] size_w = is_btb ? `MCX_NB_THREE :
                       (is_call | is_jump | is_bsr | is_dir |
                        (is_acc & fn_two)) ? `MCX_NB_TWO :
                       `MCX_NB_ONE;
  wire [11:0] seq_w = pc_q + size_w;

  // ----------------------------------------------------------------
  // branch targets
  // ----------------------------------------------------------------
  wire rel_flag = op_w[`MCX_RFLG_POS] ? c_q : z_q;
  wire rel_take = (rel_flag == op_w[`MCX_RPOL_POS]);
  wire [11:0] span_w  = {8'h00, fnr_w};
  wire [11:0] rel_tgt = op_w[`MCX_BACK_POS] ? pc_q - span_w
                        : pc_q + `MCX_NB_ONE + span_w;
  wire btb_take = (bit_q == op_w[`MCX_POL_POS]);
  wire [11:0] btb_tgt = pc_q + `MCX_NB_TWO
                        + {{4{ee_q[7]}}, ee_q};
  wire [11:0] ext_tgt = {fnr_w, b2_q};
  wire [2:0] top_idx = (sp_q == 3'h0) ? 3'(STACK_DEPTH - 1)
                       : sp_q - 3'h1;
  wire [11:0] stk_top = stk_q[top_idx];

  wire [11:0] npc_w = is_rel ? (rel_take ? rel_tgt : seq_w) :
                      (is_call | is_jump) ? ext_tgt :
                      is_btb ? (btb_take ? btb_tgt : seq_w) :
                      is_ret ? stk_top : seq_w;

  // ----------------------------------------------------------------
  // interrupt entry, at an instruction boundary or from a halt
  // ----------------------------------------------------------------
  // call and return are skipped so that two stack moves never meet
  wire take_irq = irq_req & ~in_irq_q &
                  (halted | (last_w & ~is_call & ~is_ret));
  wire [11:0] pc_next = take_irq ? irq_vec : npc_w;
  wire push_w = take_irq | (last_w & is_call);
  wire pop_w  = last_w & is_ret;
  wire [11:0] push_val = ~take_irq ? seq_w : halted ? pc_q : npc_w;

  // ----------------------------------------------------------------
  // alu operands and write-back selection
  // ----------------------------------------------------------------
  assign alu_bus.func = fn_w;
  assign alu_bus.a    = acc_q;
  assign alu_bus.b    = (is_acc & ~fn_two) ? acc_q : opnd_q;
  assign alu_bus.cin  = c_q;

  mcx_alu u_alu (
    .bus (alu_bus)
  );

  wire fn_accres = fn_two & ~fn_cp;
  // on a memory operand the accumulator-only ops do nothing
  wire acc_wr = last_w & ((is_acc & fn_alu & ~fn_cp) |
                          (is_mem & fn_accres));
  wire mem_wr = last_w & ((is_mem & (fn_step | fn_clr)) |
                          is_bsr);
  wire z_upd  = last_w & ((is_acc & fn_alu) |
                          (is_mem & (fn_two | fn_step)));
  wire c_upd  = last_w & ((is_acc & (fn_two | fn_clr | fn_rot)) |
                          (is_mem & fn_two));
  wire [7:0] bmask   = 8'h01 << bnum_w;
  wire [7:0] bsr_val = op_w[`MCX_POL_POS] ? (opnd_q | bmask)
                       : (opnd_q & ~bmask);

  assign acc_d = acc_wr ? alu_bus.res : acc_q;
  assign z_d   = (last_w & is_return_from_interrupt) ? zs_q :
                 z_upd ? alu_bus.z : z_q;
  assign c_d   = (last_w & is_return_from_interrupt) ? cs_q :
                 (last_w & is_btb) ? bit_q :
                 c_upd ? alu_bus.c : c_q;

  // ----------------------------------------------------------------
  // sequencing and memory addresses
  // ----------------------------------------------------------------
  assign step_d = (halted | last_w) ? 3'h0 : step_q + 3'h1;
  assign pc_d   = (take_irq | last_w) ? pc_next : pc_q;
  assign sp_d   = push_w ? ((sp_q == 3'(STACK_DEPTH - 1)) ? 3'h0
                            : sp_q + 3'h1) :
                  pop_w ? top_idx : sp_q;

  assign pm_addr_d = (take_irq | last_w) ? pc_next :
                     st0 ? pc_q + `MCX_NB_ONE :
                     st1 ? pc_q + `MCX_NB_TWO : pm_addr_q;

  assign ds_addr_d =
    (st0 & (cls_w == `MCX_CLS_INDX)) ? `MCX_ADDR_PTR_X :
    (st0 & (cls_w == `MCX_CLS_INDY)) ? `MCX_ADDR_PTR_Y :
    (st1 & (is_dir | is_bsr | is_btb)) ? pm_rdata :
    (st1 & is_ptr) ? ds_rdata : ds_addr_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      mcx_pkg::mcx_st_run: begin
        if (last_w && !take_irq && is_ctl) begin
          if (fn_w == mcx_pkg::mcx_fn_wait) begin
            state_d = mcx_pkg::mcx_st_wait;
          end else if (fn_w == mcx_pkg::mcx_fn_stop) begin
            state_d = wdog_sel ? mcx_pkg::mcx_st_wait
                      : mcx_pkg::mcx_st_stop;
          end
        end
      end
      mcx_pkg::mcx_st_wait, mcx_pkg::mcx_st_stop: begin
        if (irq_req) begin
          state_d = mcx_pkg::mcx_st_run;
        end
      end
      default: state_d = mcx_pkg::mcx_st_run;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q   <= mcx_pkg::mcx_st_run;
      step_q    <= 3'h0;
      pc_q      <= `MCX_RST_PC;
      pm_addr_q <= `MCX_RST_PC;
      ds_addr_q <= `MCX_RST_BYTE;
      sp_q      <= 3'h0;
      done_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      step_q    <= step_d;
      pc_q      <= pc_d;
      pm_addr_q <= pm_addr_d;
      ds_addr_q <= ds_addr_d;
      sp_q      <= sp_d;
      done_q    <= last_w;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      op_q   <= `MCX_RST_BYTE;
      b2_q   <= `MCX_RST_BYTE;
      opnd_q <= `MCX_RST_BYTE;
      ee_q   <= `MCX_RST_BYTE;
      bit_q  <= 1'b0;
    end else begin
      if (st0) op_q <= pm_rdata;
      if (st1) b2_q <= pm_rdata;
      if (st2) begin
        opnd_q <= is_acc ? b2_q : ds_rdata;
        ee_q   <= pm_rdata;
        bit_q  <= ds_rdata[bnum_w];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_q      <= `MCX_RST_BYTE;
      z_q        <= 1'b0;
      c_q        <= 1'b0;
      zs_q       <= 1'b0;
      cs_q       <= 1'b0;
      in_irq_q   <= 1'b0;
      ds_we_q    <= 1'b0;
      ds_wdata_q <= `MCX_RST_BYTE;
    end else begin
      acc_q   <= acc_d;
      z_q     <= z_d;
      c_q     <= c_d;
      ds_we_q <= mem_wr;
      if (mem_wr) ds_wdata_q <= is_bsr ? bsr_val : alu_bus.res;
      if (take_irq) begin
        zs_q     <= z_d;
        cs_q     <= c_d;
        in_irq_q <= 1'b1;
      end else if (last_w && is_return_from_interrupt) begin
        in_irq_q <= 1'b0;
      end
    end
  end

  // return-address cells, one flop group per entry
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stk
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        stk_q[i] <= `MCX_RST_PC;
      end else if (push_w && sp_q == 3'(i)) begin
        stk_q[i] <= push_val;
      end
    end
  end

  assign pm_addr    = pm_addr_q;
  assign ds_addr    = ds_addr_q;
  assign ds_wdata   = ds_wdata_q;
  assign ds_we      = ds_we_q;
  assign acc        = acc_q;
  assign flag_z     = z_q;
  assign flag_c     = c_q;
  assign wait_mode  = (state_q == mcx_pkg::mcx_st_wait);
  assign stop_mode  = (state_q == mcx_pkg::mcx_st_stop);
  assign instr_done = done_q;

endmodule

// file: verif/mcx_core_properties.sv
`timescale 1ns/1ps
module mcx_core_properties (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [11:0] pm_addr,
  input wire logic [7:0]  pm_rdata,
  input wire logic [7:0]  ds_addr,
  input wire logic [7:0]  ds_rdata,
  input wire logic [7:0]  ds_wdata,
  input wire logic        ds_we,
  input wire logic        irq_req,
  input wire logic        wdog_sel,
  input wire logic [7:0]  acc,
  input wire logic        flag_z,
  input wire logic        flag_c,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        instr_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // opcode and tested bit kept for the later steps
  // ----------------------------------------------------------------
  logic [7:0] op_q;
  logic       tbit_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      op_q   <= 8'h00;
      tbit_q <= 1'b0;
    end else begin
      op_q   <= instr_done ? pm_rdata : op_q;
      tbit_q <= ds_rdata[op_q[7:5]];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_fetch(logic [3:0] cls);
    instr_done && !irq_req && pm_rdata[3:0] == cls;
  endsequence
  sequence s_branch;
    instr_done && !irq_req && !pm_rdata[0];
  endsequence

  property p_flag_branch;
    s_branch |=> !instr_done ##1 (instr_done && flag_z == $past(flag_z, 2)
      && flag_c == $past(flag_c, 2));
  endproperty
  property p_btb_len;
    s_fetch(4'h3) |=> !instr_done [*4] ##1 instr_done;
  endproperty
  property p_btb_carry;
    s_fetch(4'h3) |-> ##5 (instr_done && flag_c == tbit_q);
  endproperty
  property p_bit_write;
    s_fetch(4'hb) |-> ##4 (instr_done && ds_we && ds_addr == $past(pm_rdata, 3)
      && ds_wdata[op_q[7:5]] == op_q[4] && flag_c == $past(flag_c, 4));
  endproperty
  property p_jump;
    s_fetch(4'h9) |-> ##4 (instr_done
      && pm_addr == {op_q[7:4], $past(pm_rdata, 3)});
  endproperty
  property p_inc_mem;
    (instr_done && !irq_req && pm_rdata == 8'h4d) |-> ##4 (ds_we
      && ds_wdata == 8'($past(ds_rdata) + 8'h01)
      && flag_c == $past(flag_c, 4));
  endproperty
  property p_add;
    (instr_done && !irq_req && pm_rdata == 8'h0d)
      |-> ##4 (acc == 8'($past(acc, 4) + $past(ds_rdata, 2)));
  endproperty
  property p_acc_only;
    (instr_done && pm_rdata[3:0] == 4'h5 && pm_rdata[7:4] inside {[4'h7:4'h9]})
      |=> !ds_we [*4];
  endproperty
  property p_stop_wait;
    (instr_done && wdog_sel && pm_rdata == 8'hd5)
      |-> ##[1:4] (wait_mode && !stop_mode);
  endproperty

  a_flag_branch: assert property (p_flag_branch)
    else $error("branch flags");
  a_btb_len: assert property (p_btb_len)
    else $error("bit test length");
  a_btb_carry: assert property (p_btb_carry)
    else $error("bit test carry");
  a_bit_write: assert property (p_bit_write)
    else $error("bit write");
  a_jump: assert property (p_jump)
    else $error("jump target");
  a_inc_mem: assert property (p_inc_mem)
    else $error("increment write");
  a_add: assert property (p_add)
    else $error("add result");
  a_acc_only: assert property (p_acc_only)
    else $error("memory touched");
  a_stop_wait: assert property (p_stop_wait)
    else $error("stop not wait");
endmodule

bind mcx_core mcx_core_properties u_props (
  .clk_sys(clk_sys), .resetn(resetn), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
  .ds_addr(ds_addr), .ds_rdata(ds_rdata), .ds_wdata(ds_wdata), .ds_we(ds_we),
  .irq_req(irq_req), .wdog_sel(wdog_sel), .acc(acc), .flag_z(flag_z),
  .flag_c(flag_c), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .instr_done(instr_done));

// file: verif/mcx_mem_model.sv
`timescale 1ns/1ps
module mcx_mem_model (
  input  wire logic        clk_sys,
  input  wire logic [11:0] pm_addr,
  output logic      [7:0]  pm_rdata,
  input  wire logic [7:0]  ds_addr,
  output logic      [7:0]  ds_rdata,
  input  wire logic [7:0]  ds_wdata,
  input  wire logic        ds_we
);
  // zero-wait arrays: the core samples read data in the address cycle
  logic [7:0] pm [4096];
  logic [7:0] ds [256];
  assign pm_rdata = pm[pm_addr];
  assign ds_rdata = ds[ds_addr];
  always @(posedge clk_sys) begin
    if (ds_we) begin
      ds[ds_addr] <= ds_wdata;
    end
  end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, resetn, ds_we, irq_req, wdog_sel, flag_z, flag_c;
  logic wait_mode, stop_mode, instr_done, m_z, m_c, x_we;
  logic [11:0] pm_addr, irq_vec, m_pc;
  logic [7:0]  pm_rdata, ds_addr, ds_rdata, ds_wdata, acc, m_a, x_wa, x_wd;
  logic [7:0]  m_ds [256];
  int          error_cnt, comparisons, m_len, seed;

  mcx_core uut (.clk_sys(clk_sys), .resetn(resetn), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .ds_addr(ds_addr), .ds_rdata(ds_rdata),
    .ds_wdata(ds_wdata), .ds_we(ds_we), .irq_req(irq_req), .irq_vec(irq_vec),
    .wdog_sel(wdog_sel), .acc(acc), .flag_z(flag_z), .flag_c(flag_c),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .instr_done(instr_done));
  mcx_mem_model u_mem (.clk_sys(clk_sys), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .ds_addr(ds_addr), .ds_rdata(ds_rdata),
    .ds_wdata(ds_wdata), .ds_we(ds_we));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // checking and pacing
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv,
                     input string what);
    comparisons++;
    if (seen !== expv) begin
      error_cnt++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, expv);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic stall();
    error_cnt++;
    $display("wrong value at %0t: core hung", $time);
    summarize();
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_done(output int n);
    n = 0;
    do begin
      tick();
      n++;
    end while (instr_done !== 1'b1 && n < 50);
    if (instr_done !== 1'b1) stall();
  endtask
  task automatic do_reset();
    repeat (3) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // reference model: one instruction at m_pc
  // ----------------------------------------------------------------
  task automatic step();
    logic [7:0] op, b2, b3, v, r, ad;
    logic [8:0] s;
    logic [3:0] f;
    logic       mem;
    op = u_mem.pm[m_pc];
    b2 = u_mem.pm[m_pc + 12'h001];
    b3 = u_mem.pm[m_pc + 12'h002];
    f = op[7:4];
    mem = op[3:0] != 4'h5;
    ad = (op[2:0] == 3'b111) ? m_ds[{7'h40, op[3]}] : b2;
    v = m_ds[ad];
    m_len = 4;
    x_we = 1'b0;
    x_wa = ad;
    if (!op[0]) begin
      m_len = 2;
      if ((op[1] ? m_c : m_z) == op[2]) begin
        m_pc = op[3] ? m_pc - 12'(f) : m_pc + 12'h001 + 12'(f);
      end else begin
        m_pc = m_pc + 12'h001;
      end
    end else if (op[3:0] == 4'h9) begin
      m_pc = {f, b2};
    end else if (op[3:0] == 4'h3) begin
      m_len = 5;
      m_c = v[op[7:5]];
      m_pc = m_pc + ((m_c == op[4]) ? 12'h002 + {{4{b3[7]}}, b3} : 12'h003);
    end else if (op[3:0] == 4'hb) begin
      v[op[7:5]] = op[4];
      {x_we, x_wd, m_ds[ad]} = {1'b1, v, v};
      m_pc = m_pc + 12'h002;
    end else begin
      if (!mem) v = (f < 4'h4) ? b2 : m_a;
      m_pc = m_pc + ((op[1] || (!mem && f > 4'h3)) ? 12'h001 : 12'h002);
      if (f < 4'h4) begin
        s = {1'b0, m_a} + {1'b0, v};
        r = (f == 4'h0) ? s[7:0] : (f == 4'h1) ? (m_a & v) : m_a - v;
        m_c = (f == 4'h0) ? s[8] : (f == 4'h1) ? 1'b0 : (m_a < v);
        m_z = (r == 8'h00);
        if (f != 4'h2) m_a = r;
      end else if (f < 4'h7) begin
        r = (f == 4'h4) ? v + 8'h01 : (f == 4'h5) ? v - 8'h01 : 8'h00;
        if (mem) {x_we, x_wd, m_ds[ad]} = {1'b1, r, r};
        else m_a = r;
        if (!(mem && f == 4'h6)) m_z = (r == 8'h00);
        if (!mem && f == 4'h6) m_c = 1'b0;
      end else if (!mem && f < 4'ha) begin
        r = (f == 4'h7) ? ~m_a : {m_a[6:0], ((f == 4'h8) ? m_c : 1'b0)};
        {m_c, m_a, m_z} = {m_a[7], r, r == 8'h00};
      end else if (!mem) begin
        m_len = 2;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  task automatic rand_round();
    logic [7:0] b;
    int n;
    resetn = 1'b0;
    // calls and the control ops that leave the flow are kept for ctl_round
    for (int i = 0; i < 4096; i++) begin
      do b = 8'($urandom);
      while (b[3:0] == 4'h1 ||
             (b[3:0] == 4'h5 && b[7:4] inside {[4'hb:4'he]}));
      u_mem.pm[i] = b;
    end
    for (int i = 0; i < 256; i++) begin
      m_ds[i] = 8'($urandom);
      u_mem.ds[i] = m_ds[i];
    end
    irq_vec = 12'($urandom);
    wdog_sel = 1'($urandom);
    do_reset();
    {m_pc, m_a, m_z, m_c} = '0;
    for (int k = 0; k < 200; k++) begin
      step();
      wait_done(n);
      chk(16'(n), 16'(m_len), "cycles");
      chk(16'(pm_addr), 16'(m_pc), "next address");
      chk(16'(acc), 16'(m_a), "accumulator");
      chk(16'({flag_z, flag_c}), 16'({m_z, m_c}), "flags");
      chk(16'(ds_we), 16'(x_we), "write strobe");
      if (x_we) chk({ds_addr, ds_wdata}, {x_wa, x_wd}, "write");
    end
  endtask

  task automatic ctl_round(input logic w);
    int n;
    logic [11:0] pcs [4];
    int lens [4];
    resetn = 1'b0;
    pcs = '{12'h002, 12'h010, 12'h011, 12'h004};
    lens = '{4, 4, 2, 2};
    for (int i = 0; i < 64; i++) u_mem.pm[i] = 8'ha5;
    {u_mem.pm[0], u_mem.pm[1], u_mem.pm[2], u_mem.pm[3]} = 32'h2501_0110;
    {u_mem.pm[4], u_mem.pm[6], u_mem.pm[7]} = 24'hd5_0906;
    // the resume point after the handler holds a wait
    u_mem.pm[5] = 8'he5;
    {u_mem.pm[17], u_mem.pm[32], u_mem.pm[33]} = 24'hb5_65c5;
    irq_vec = 12'h020;
    wdog_sel = w;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      wait_done(n);
      chk(16'(pm_addr), 16'(pcs[i]), "flow");
      chk(16'(n), 16'(lens[i]), "cycles");
      chk(16'({flag_z, flag_c}), 16'h0001, "flags kept");
    end
    wait_done(n);
    repeat (2) tick();
    chk(16'({wait_mode, stop_mode}), 16'({w, !w}), "low power");
    irq_req = 1'b1;
    n = 0;
    while (pm_addr !== 12'h020 && n < 50) begin
      tick();
      n++;
    end
    if (pm_addr !== 12'h020) stall();
    irq_req = 1'b0;
    wait_done(n);
    chk(16'({flag_z, flag_c}), 16'h0002, "handler flags");
    wait_done(n);
    chk(16'(pm_addr), 16'h0005, "resume");
    chk(16'({flag_z, flag_c}), 16'h0001, "restored flags");
    wait_done(n);
    chk(16'(n), 16'h0002, "wait cycles");
    chk(16'({wait_mode, stop_mode, flag_z, flag_c}), 16'h0009, "wait");
  endtask

  initial begin
    {resetn, irq_req, wdog_sel, irq_vec} = '0;
    {error_cnt, comparisons} = '0;
    seed = $urandom(32'h4b1696cb);
    for (int r = 0; r < 6; r++) begin
      rand_round();
      $display("random round %0d finished", r);
    end
    ctl_round(1'b1);
    $display("control flow with watchdog finished");
    ctl_round(1'b0);
    $display("control flow without watchdog finished");
    summarize();
  end
endmodule
